// ==== rtl/gearbox_pkg.sv ====
package gearbox_pkg;

  // receive gearing modes
  typedef enum logic [1:0] {
    MODE_X5_CENTRED = 2'h0,
    MODE_X5_ALIGNED = 2'h1,
    MODE_X71        = 2'h2,
    MODE_X4_MIPI    = 2'h3
  } mode_e;

  // startup sync states, gray along the path
  typedef enum logic [2:0] {
    SYNC_IDLE  = 3'h0,
    SYNC_STOP  = 3'h1,
    SYNC_RESET = 3'h3,
    SYNC_START = 3'h2,
    SYNC_READY = 3'h6
  } sync_e;

  // delay-lock update sequencer states
  typedef enum logic [1:0] {
    DLL_WAIT    = 2'h0,
    DLL_UPDATE  = 2'h1,
    DLL_RELEASE = 2'h3,
    DLL_RUN     = 2'h2
  } dll_e;

  localparam int LANES    = 2;
  localparam int MAX_GEAR = 7;
  localparam int WORD_W   = LANES * MAX_GEAR;
  localparam int TAP_W    = 4;
  localparam int TAP_N    = 16;

  // register offsets
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_DELAY  = 8'h04;
  localparam logic [7:0] REG_DSTEP  = 8'h08;
  localparam logic [7:0] REG_MARGIN = 8'h0C;
  localparam logic [7:0] REG_PHASE  = 8'h10;
  localparam logic [7:0] REG_STATUS = 8'h14;
  localparam logic [7:0] REG_WORD   = 8'h18;

  // control field positions
  localparam int CTRL_MODE_LO   = 0;
  localparam int CTRL_STOPALIGN = 2;
  localparam int CTRL_DYNDELAY  = 3;
  localparam int CTRL_WALIGN    = 4;
  localparam int CTRL_MARGIN    = 5;
  localparam logic [5:0] CTRL_RESET = 6'h00;

  // fixed delay taps per interface type
  localparam logic [3:0] TAP_X5_CENTRED = 4'h3;
  localparam logic [3:0] TAP_X5_ALIGNED = 4'h1;
  localparam logic [3:0] TAP_X71        = 4'h2;
  localparam logic [3:0] TAP_X4_MIPI    = 4'h4;
  localparam logic [3:0] TAP_RESET      = 4'h0;

  // gearing ratios
  localparam logic [2:0] GEAR_X5  = 3'h5;
  localparam logic [2:0] GEAR_X4  = 3'h4;
  localparam logic [2:0] GEAR_X71 = 3'h7;

  // expected forwarded-clock word at the right boundary
  localparam logic [6:0] CLK_WORD_OK = 7'h63;

  // startup timing
  localparam int CLK_NS         = 10;
  localparam int STOP_NS        = 80;
  localparam int RESET_NS       = 40;
  localparam int START_NS       = 80;
  localparam int STOP_CYCLES    = (STOP_NS + CLK_NS - 1) / CLK_NS;
  localparam int RESET_CYCLES   = (RESET_NS + CLK_NS - 1) / CLK_NS;
  localparam int START_CYCLES   = (START_NS + CLK_NS - 1) / CLK_NS;
  localparam int SLIP_HOLD_WORDS = 3;

endpackage

// ==== rtl/delay_tap_line.sv ====
`timescale 1ns/1ns
// selectable tap delay of one bit stream
module delay_tap_line
  import gearbox_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             din,
  input  wire logic [TAP_W-1:0] tap,
  output logic                  dout
);

  logic [TAP_N-1:0] line;
  wire              tapped = line[tap];

  // shift chain; tap 0 gives two cycles of delay
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      line <= '0;
      dout <= 1'b0;
    end else begin
      line <= {line[TAP_N-2:0], din};
      dout <= tapped;
    end
  end

endmodule // delay_tap_line

// ==== rtl/gearbox_ddr_receiver.sv ====
// Design decisions made here: the plain strobed port and the register offsets.
`timescale 1ns/1ns
// How it works
// - five-to-one mode shifts serial bits on edge clock, emits word every five bits
// - each data input passes a fixed delay before the capture register
// - software may step a dynamic delay that overrides the fixed value
// - delay value is chosen by interface type and gearing
// - aligned mode shifts clock by delay cell fed codes from the lock loop
// - optional margin offset trims the clock delay in aligned mode
// - seven-to-one mode uses a dynamic phase select for the sampling point
// - seven-to-one word clock is the edge clock divided over seven bits
// - a second deserialiser samples the forwarded clock into a 7-bit word
// - word aligner pulses slip until the 7-bit boundary matches
// - MIPI path uses four-to-one gearing with centred clock
// - startup engine runs on the free clock, held while its reset is high
// - output word is lanes times gearing bits, timed by byte clock
// - gate aligns clock while stop is high only if stop-align enabled
// - link-ready rises once divider and deserialisers are synchronised
module gearbox_ddr_receiver
  import gearbox_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic [LANES-1:0]  serIn,
  input  wire logic              fwdClkIn,
  input  wire logic              syncRstIn,
  input  wire logic              fastRxEnableIn,
  input  wire logic              dllLockIn,
  input  wire logic [TAP_W-1:0]  dllCodeIn,
  input  wire logic [7:0]        regAddr,
  input  wire logic [31:0]       regWdata,
  input  wire logic              regWr,
  input  wire logic              regRd,
  output logic [31:0]            regRdata,
  output logic [WORD_W-1:0]      fastRxWordOut,
  output logic                   wordValid,
  output logic                   byteClk,
  output logic                   linkReady,
  output logic                   edgeStop,
  output logic                   divReset,
  output logic                   dllFreeze,
  output logic                   dllUpdate,
  output logic                   wordSlip,
  output logic [TAP_W-1:0]       phaseSel
);

  localparam int PIN_W = LANES + 2;

  // decode helpers
  function automatic logic [2:0] gearOf(input logic [1:0] m);
    case (m)
      MODE_X71:     gearOf = GEAR_X71;
      MODE_X4_MIPI: gearOf = GEAR_X4;
      default:      gearOf = GEAR_X5;
    endcase
  endfunction

  function automatic logic [TAP_W-1:0] fixedTap(input logic [1:0] m);
    case (m)
      MODE_X5_ALIGNED: fixedTap = TAP_X5_ALIGNED;
      MODE_X71:        fixedTap = TAP_X71;
      MODE_X4_MIPI:    fixedTap = TAP_X4_MIPI;
      default:         fixedTap = TAP_X5_CENTRED;
    endcase
  endfunction

  // pin synchronisers: three flops, change taken when 2nd and 3rd agree
  logic [PIN_W-1:0] pinS1;
  logic [PIN_W-1:0] pinS2;
  logic [PIN_W-1:0] pinS3;
  logic [PIN_W-1:0] pinVal;
  wire  [PIN_W-1:0] pinRaw   = {syncRstIn, fwdClkIn, serIn};
  wire  [PIN_W-1:0] pinAgree = ~(pinS2 ^ pinS3);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pinS1  <= '0;
      pinS2  <= '0;
      pinS3  <= '0;
      pinVal <= '0;
    end else begin
      pinS1  <= pinRaw;
      pinS2  <= pinS1;
      pinS3  <= pinS2;
      pinVal <= (pinVal & ~pinAgree) | (pinS3 & pinAgree);
    end
  end

  wire [LANES-1:0] serSync  = pinVal[LANES-1:0];
  wire             fwdSync  = pinVal[LANES];
  wire             syncHold = pinVal[LANES+1];

  // control registers
  logic [5:0]       ctrl;
  logic [TAP_W-1:0] dynTap;
  logic [TAP_W-1:0] margin;
  logic [TAP_W-1:0] appliedCode;
  logic [7:0]       slipCount;
  logic             wordAligned;
  sync_e            syncState;
  dll_e             dllState;

  wire [1:0] mode        = ctrl[CTRL_MODE_LO +: 2];
  wire       stopAlignEn = ctrl[CTRL_STOPALIGN];
  wire       useDynDelay = ctrl[CTRL_DYNDELAY];
  wire       walignEn    = ctrl[CTRL_WALIGN];
  wire       marginEn    = ctrl[CTRL_MARGIN];
  wire       isAligned   = (mode == MODE_X5_ALIGNED);
  wire       isX71       = (mode == MODE_X71);

  // register bus decode
  wire selCtrl   = (regAddr == REG_CTRL);
  wire selDelay  = (regAddr == REG_DELAY);
  wire selDstep  = (regAddr == REG_DSTEP);
  wire selMargin = (regAddr == REG_MARGIN);
  wire selPhase  = (regAddr == REG_PHASE);
  wire selStatus = (regAddr == REG_STATUS);
  wire selWord   = (regAddr == REG_WORD);

  wire stepUp   = regWr && selDstep && regWdata[0] && (dynTap != '1);
  wire stepDown = regWr && selDstep && regWdata[1] && (dynTap != '0);

  wire [31:0] statusWord = {16'h0000, slipCount, 2'b00, syncState,
                            wordAligned, (dllState == DLL_RUN), linkReady};

  wire [31:0] next_regRdata =
      selCtrl   ? {26'h000_0000, ctrl} :
      selDelay  ? {28'h000_0000, dynTap} :
      selMargin ? {28'h000_0000, margin} :
      selPhase  ? {28'h000_0000, phaseSel} :
      selStatus ? statusWord :
      selWord   ? {{(32-WORD_W){1'b0}}, fastRxWordOut} :
                  32'h0000_0000;

  // register writes; delay step saturates at both ends
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl     <= CTRL_RESET;
      dynTap   <= TAP_RESET;
      margin   <= TAP_RESET;
      phaseSel <= TAP_RESET;
    end else begin
      if (regWr && selCtrl)   ctrl     <= regWdata[5:0];
      if (regWr && selMargin) margin   <= regWdata[TAP_W-1:0];
      if (regWr && selPhase)  phaseSel <= regWdata[TAP_W-1:0];
      if (regWr && selDelay)  dynTap   <= regWdata[TAP_W-1:0];
      else if (stepUp)        dynTap   <= dynTap + 1'b1;
      else if (stepDown)      dynTap   <= dynTap - 1'b1;
    end
  end

  // read data stands the cycle after the strobe only
  always_ff @(posedge clk or posedge rst) begin
    if (rst) regRdata <= '0;
    else     regRdata <= regRd ? next_regRdata : 32'h0000_0000;
  end

  // startup sync engine: stop gate, reset divider, restart, ready
  logic [3:0] syncCnt;
  sync_e      next_syncState;
  wire        syncDone = (syncCnt == 4'h0);

  always_comb begin
    next_syncState = syncState;
    case (syncState)
      SYNC_IDLE:  next_syncState = SYNC_STOP;
      SYNC_STOP:  if (syncDone) next_syncState = SYNC_RESET;
      SYNC_RESET: if (syncDone) next_syncState = SYNC_START;
      SYNC_START: if (syncDone) next_syncState = SYNC_READY;
      SYNC_READY: next_syncState = SYNC_READY;
      default:    next_syncState = SYNC_IDLE;
    endcase
  end

  wire [3:0] syncLoad =
      (next_syncState == SYNC_STOP)  ? 4'(STOP_CYCLES - 1) :
      (next_syncState == SYNC_RESET) ? 4'(RESET_CYCLES - 1) :
      (next_syncState == SYNC_START) ? 4'(START_CYCLES - 1) : 4'h0;

  // held in idle while the engine reset pin is high
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      syncState <= SYNC_IDLE;
      syncCnt   <= 4'h0;
    end else if (syncHold) begin
      syncState <= SYNC_IDLE;
      syncCnt   <= 4'h0;
    end else begin
      syncState <= next_syncState;
      syncCnt   <= (next_syncState != syncState) ? syncLoad :
                   (syncDone ? 4'h0 : syncCnt - 4'h1);
    end
  end

  // gate stop rises with the divider reset and is held past its release
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      edgeStop  <= 1'b1;
      divReset  <= 1'b1;
      linkReady <= 1'b0;
    end else begin
      edgeStop  <= (next_syncState != SYNC_READY) &&
                   (next_syncState != SYNC_START);
      divReset  <= (next_syncState == SYNC_IDLE) ||
                   (next_syncState == SYNC_STOP);
      linkReady <= (next_syncState == SYNC_READY) && !syncHold;
    end
  end

  // delay-lock sequencer: freeze until lock, apply code, release
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dllState    <= DLL_WAIT;
      appliedCode <= TAP_RESET;
    end else begin
      case (dllState)
        DLL_WAIT:    if (dllLockIn) dllState <= DLL_UPDATE;
        DLL_UPDATE: begin
          appliedCode <= dllCodeIn;
          dllState    <= DLL_RELEASE;
        end
        DLL_RELEASE: dllState <= DLL_RUN;
        DLL_RUN: begin
          if (!dllLockIn) dllState <= DLL_WAIT;
          else appliedCode <= dllCodeIn;
        end
        default:     dllState <= DLL_WAIT;
      endcase
    end
  end

  assign dllFreeze = (dllState != DLL_RUN);
  assign dllUpdate = (dllState == DLL_UPDATE);

  // tap selection per interface type
  wire [TAP_W-1:0] baseTap = useDynDelay ? dynTap : fixedTap(mode);
  wire [TAP_W-1:0] dataTap = isX71 ? TAP_W'(baseTap + phaseSel) : baseTap;
  wire [TAP_W-1:0] trim    = marginEn ? margin : TAP_RESET;
  wire [TAP_W-1:0] clkTap  =
      isAligned ? TAP_W'(appliedCode + trim) :
      isX71     ? phaseSel : fixedTap(mode);

  logic [LANES-1:0] serDly;
  logic             fwdDly;

  // fixed or stepped delay ahead of each capture register
  for (genvar i = 0; i < LANES; i++) begin : g_lane_dly
    delay_tap_line u_dly (
      .clk  (clk),
      .rst  (rst),
      .din  (serSync[i]),
      .tap  (dataTap),
      .dout (serDly[i])
    );
  end

  delay_tap_line u_clk_dly (
    .clk  (clk),
    .rst  (rst),
    .din  (fwdSync),
    .tap  (clkTap),
    .dout (fwdDly)
  );

  // gear counter: divider reset or stop-align parks it at zero
  logic [2:0] bitCnt;
  wire  [2:0] gear      = gearOf(mode);
  wire        alignHold = edgeStop && stopAlignEn;
  wire        wordEnd   = (bitCnt == 3'(gear - 3'h1));
  wire        divHold   = divReset || alignHold;

  always_ff @(posedge clk or posedge rst) begin
    if (rst)            bitCnt <= 3'h0;
    else if (divHold)   bitCnt <= 3'h0;
    else if (wordSlip)  bitCnt <= bitCnt;
    else if (wordEnd)   bitCnt <= 3'h0;
    else                bitCnt <= bitCnt + 3'h1;
  end

  // deserialisers: data lanes and forwarded clock as data
  logic [MAX_GEAR-1:0] laneShift [LANES];
  logic [MAX_GEAR-1:0] clkShift;
  logic [MAX_GEAR-1:0] clkWord;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < LANES; i++) laneShift[i] <= '0;
      clkShift <= '0;
    end else if (!divReset && !wordSlip) begin
      for (int i = 0; i < LANES; i++)
        laneShift[i] <= {laneShift[i][MAX_GEAR-2:0], serDly[i]};
      clkShift <= {clkShift[MAX_GEAR-2:0], fwdDly};
    end
  end

  // assemble lanes times gear bits, newest bit at bit zero
  logic [WORD_W-1:0] gathered;
  always_comb begin
    gathered = '0;
    for (int i = 0; i < LANES; i++)
      gathered[i*MAX_GEAR +: MAX_GEAR] =
        {laneShift[i][MAX_GEAR-2:0], serDly[i]} &
        MAX_GEAR'((8'h01 << gear) - 8'h01);
  end

  wire wordTake = wordEnd && !divHold && !wordSlip;
  wire deliver  = wordTake && linkReady && fastRxEnableIn;

  // word output and byte clock, both from flops
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fastRxWordOut <= '0;
      wordValid     <= 1'b0;
      byteClk       <= 1'b0;
      clkWord       <= '0;
    end else begin
      wordValid <= deliver;
      byteClk   <= !divHold && (bitCnt < (gear >> 1));
      if (deliver) fastRxWordOut <= gathered;
      if (wordTake) clkWord <= {clkShift[MAX_GEAR-2:0], fwdDly};
    end
  end

  // word aligner: slip one bit, wait a few words, check again
  logic [1:0] holdWords;
  wire        clkMatch  = (clkWord == CLK_WORD_OK);
  wire        checkNow  = isX71 && walignEn && linkReady && wordTake &&
                          (holdWords == 2'h0);
  wire        next_slip = checkNow && !clkMatch;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wordSlip    <= 1'b0;
      holdWords   <= 2'h0;
      wordAligned <= 1'b0;
      slipCount   <= 8'h00;
    end else begin
      wordSlip <= next_slip;
      if (next_slip)
        holdWords <= 2'(SLIP_HOLD_WORDS);
      else if (wordTake && holdWords != 2'h0)
        holdWords <= holdWords - 2'h1;
      if (!linkReady || !walignEn || !isX71)
        wordAligned <= 1'b0;
      else if (checkNow)
        wordAligned <= clkMatch;
      if (!linkReady)
        slipCount <= 8'h00;
      else if (next_slip && slipCount != 8'hFF)
        slipCount <= slipCount + 8'h01;
    end
  end

endmodule // gearbox_ddr_receiver

// ==== verification/gearbox_asserts.sv ====
`timescale 1ns/1ns
module gearbox_asserts
  import gearbox_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        regRd,
  input wire logic [31:0] regRdata,
  input wire logic        wordValid,
  input wire logic        fastRxEnableIn,
  input wire logic        linkReady,
  input wire logic        edgeStop,
  input wire logic        divReset,
  input wire logic        byteClk,
  input wire logic        dllLockIn,
  input wire logic        dllFreeze,
  input wire logic        dllUpdate,
  input wire logic        wordSlip
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // lock sequencer: load, release, then run
  sequence s_dll_steps;
    dllFreeze ##1 (dllFreeze && !dllUpdate) ##1 !dllFreeze;
  endsequence
  // divider reset phase with the gate still stopped
  sequence s_reset_phase;
    edgeStop [*4] ##1 !edgeStop;
  endsequence

  // properties
  property p_rdata_idle;
    !$past(regRd) |-> regRdata == 32'h0000_0000;
  endproperty
  property p_valid_pulse;
    wordValid |=> !wordValid;
  endproperty
  property p_valid_gated;
    wordValid |-> $past(linkReady) && $past(fastRxEnableIn);
  endproperty
  property p_stop_order;
    $fell(divReset) |-> s_reset_phase;
  endproperty
  property p_ready_wait;
    $fell(edgeStop) |-> !linkReady [*8] ##[1:2] linkReady;
  endproperty
  property p_dll_steps;
    dllUpdate |-> s_dll_steps;
  endproperty
  property p_no_lock;
    !dllLockIn |=> dllFreeze && !dllUpdate;
  endproperty
  property p_slip_gap;
    wordSlip |=> !wordSlip [*7];
  endproperty
  property p_byte_held;
    divReset && $past(divReset) |-> !byteClk;
  endproperty

  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside slot");
  a_valid_pulse: assert property (p_valid_pulse) else $error("word valid too long");
  a_valid_gated: assert property (p_valid_gated) else $error("word before ready");
  a_stop_order: assert property (p_stop_order) else $error("stop and reset out of order");
  a_ready_wait: assert property (p_ready_wait) else $error("ready timing off");
  a_dll_steps: assert property (p_dll_steps) else $error("lock sequence off");
  a_no_lock: assert property (p_no_lock) else $error("update without lock");
  a_slip_gap: assert property (p_slip_gap) else $error("slip too soon");
  a_byte_held: assert property (p_byte_held) else $error("byte clock while held");
endmodule // gearbox_asserts

// ==== verification/serial_source.sv ====
`timescale 1ns/1ns
module serial_source
  import gearbox_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              run,
  input  wire logic [2:0]        gear,
  input  wire logic [WORD_W-1:0] pattern,
  input  wire logic [2:0]        skew,
  output logic      [LANES-1:0]  serIn,
  output logic                   fwdClkIn
);
  logic [2:0] bitIdx;
  logic [2:0] clkIdx;
  wire  [2:0] lastIdx = gear - 3'h1;

  // words msb first, forwarded clock word every seven bits
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bitIdx   <= 3'h0;
      clkIdx   <= skew;
      serIn    <= '0;
      fwdClkIn <= 1'b0;
    end else if (!run) begin
      serIn    <= ~serIn; // idle lines keep moving
      fwdClkIn <= ~fwdClkIn;
    end else begin
      for (int i = 0; i < LANES; i++) serIn[i] <= pattern[i*MAX_GEAR + int'(lastIdx - bitIdx)];
      fwdClkIn <= CLK_WORD_OK[3'h6 - clkIdx];
      bitIdx   <= (bitIdx >= lastIdx) ? 3'h0 : bitIdx + 3'h1;
      clkIdx   <= (clkIdx == 3'h6) ? 3'h0 : clkIdx + 3'h1;
    end
  end
endmodule // serial_source

// ==== verification/tb.sv ====
`timescale 1ns/1ns
module tb;
  import gearbox_pkg::*;
  logic              clk            = 1'b0;
  logic              rst            = 1'b1;
  logic              syncRstIn      = 1'b0;
  logic              fastRxEnableIn = 1'b1;
  logic              dllLockIn      = 1'b0;
  logic [TAP_W-1:0]  dllCodeIn      = 4'h9;
  logic [7:0]        regAddr        = 8'h00;
  logic [31:0]       regWdata       = 32'h0000_0000;
  logic              regWr          = 1'b0;
  logic              regRd          = 1'b0;
  logic              run            = 1'b0;
  logic [2:0]        gear           = GEAR_X5;
  logic [2:0]        gearTab [4]    = '{GEAR_X5, GEAR_X5, GEAR_X71, GEAR_X4};
  logic [LANES-1:0]  serIn;
  logic [31:0]       regRdata;
  logic [31:0]       d;
  logic [WORD_W-1:0] fastRxWordOut;
  logic [TAP_W-1:0]  phaseSel;
  logic              fwdClkIn, wordValid, byteClk, linkReady, edgeStop, divReset, dllFreeze, dllUpdate, wordSlip;
  int                checks         = 0;
  int                error_cnt      = 0;
  int                cyc            = 0;
  int                n;

  always #5 clk = ~clk;

  gearbox_ddr_receiver gearbox_ddr_receiver_inst (.clk, .rst, .serIn, .fwdClkIn, .syncRstIn, .fastRxEnableIn,
    .dllLockIn, .dllCodeIn, .regAddr, .regWdata, .regWr, .regRd, .regRdata, .fastRxWordOut, .wordValid,
    .byteClk, .linkReady, .edgeStop, .divReset, .dllFreeze, .dllUpdate, .wordSlip, .phaseSel);
  serial_source serial_source_inst (.clk, .rst, .run, .gear, .pattern(14'h007F), .skew(3'h3), .serIn, .fwdClkIn);

  // one-cycle register write
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    regAddr  <= a;
    regWdata <= v;
    regWr    <= 1'b1;
    @(posedge clk);
    regWr    <= 1'b0;
  endtask

  // read, data taken in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge clk);
    regRd   <= 1'b0;
    #1;
    v = regRdata;
  endtask

  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", s, e, g);
    end
  endtask

  // cycles until the next word, 60 when none
  task automatic waitWord(output int k);
    k = 0;
    repeat (60) begin
      @(posedge clk);
      #1;
      k++;
      if (wordValid === 1'b1) break;
    end
  endtask

  task automatic waitReady();
    repeat (100) begin
      @(posedge clk);
      #1;
      if (linkReady === 1'b1) break;
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // run ceiling
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      test_done();
    end
  end

  // main sequence
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    run <= 1'b1;
    rd(REG_CTRL, d);
    chk("ctrl", {26'h0, CTRL_RESET}, d);
    chk("freeze", 32'h1, {31'h0, dllFreeze});
    @(posedge clk);
    dllLockIn <= 1'b1;
    waitReady();
    chk("ready", 32'h1, {31'h0, linkReady});
    rd(REG_STATUS, d);
    chk("status", 32'h33, d & 32'h3B);
    $display("test startup done");
    rd(8'hFC, d);
    chk("unmapped", 32'h0, d);
    wr(REG_DELAY, 32'hF);
    wr(REG_DSTEP, 32'h1);
    rd(REG_DELAY, d);
    chk("delay top", 32'hF, d);
    wr(REG_DSTEP, 32'h2);
    rd(REG_DELAY, d);
    chk("delay down", 32'hE, d);
    wr(REG_DELAY, 32'h0);
    wr(REG_DSTEP, 32'h2);
    rd(REG_DELAY, d);
    chk("delay floor", 32'h0, d);
    wr(REG_MARGIN, 32'h5);
    rd(REG_MARGIN, d);
    chk("margin", 32'h5, d);
    for (int i = 0; i < TAP_N; i++) begin
      wr(REG_PHASE, 32'(i));
      #1;
      chk("phase", 32'(i), {28'h0, phaseSel});
    end
    $display("test registers done");
    for (int m = 0; m < 4; m++) begin
      wr(REG_CTRL, 32'(m));
      gear <= gearTab[m];
      waitWord(n);
      waitWord(n);
      waitWord(n);
      chk("spacing", 32'(gearTab[m]), 32'(n));
      chk("word", 32'((1 << gearTab[m]) - 1), 32'(fastRxWordOut));
    end
    $display("test gearing done");
    @(posedge clk);
    fastRxEnableIn <= 1'b0;
    waitWord(n);
    chk("dropped", 32'd60, 32'(n));
    @(posedge clk);
    fastRxEnableIn <= 1'b1;
    $display("test enable done");
    wr(REG_CTRL, 32'h0000_0012);
    gear <= GEAR_X71;
    repeat (400) @(posedge clk);
    rd(REG_STATUS, d);
    chk("aligned", 32'h4, d & 32'h4);
    $display("test align done");
    wr(REG_CTRL, 32'h0000_0016);
    syncRstIn <= 1'b1;
    repeat (10) @(posedge clk);
    #1;
    chk("held", 32'h3, {30'h0, edgeStop, divReset});
    chk("not ready", 32'h0, {31'h0, linkReady});
    @(posedge clk);
    syncRstIn <= 1'b0;
    // stop-align on: byte clock must stay low while the gate is stopped
    n = 0;
    repeat (100) begin
      @(posedge clk);
      #1;
      if (edgeStop === 1'b1 && byteClk !== 1'b0) n++;
      if (linkReady === 1'b1) break;
    end
    chk("stop align byte", 32'h0, 32'(n));
    chk("ready again", 32'h1, {31'h0, linkReady});
    $display("test restart done");
    test_done();
  end
endmodule // tb

bind gearbox_ddr_receiver gearbox_asserts gearbox_asserts_inst (.clk(clk), .rst(rst), .regRd(regRd),
  .regRdata(regRdata), .wordValid(wordValid), .fastRxEnableIn(fastRxEnableIn), .linkReady(linkReady),
  .edgeStop(edgeStop), .divReset(divReset), .byteClk(byteClk), .dllLockIn(dllLockIn), .dllFreeze(dllFreeze),
  .dllUpdate(dllUpdate), .wordSlip(wordSlip));
